// File: pkg/adc_ctl_pkg.sv
// Constants shared by the converter control block and its helpers.
// Assumes a 200 MHz system clock and modulators stepped by a strobe.
package adc_ctl_pkg;
	localparam int CLK_HZ      = 200_000_000;
	localparam int MOD_HZ      = 512_000;
	localparam int MOD_DIV     = CLK_HZ / MOD_HZ;
	localparam int RATE_MIN_HZ = 10;
	localparam int RATE_MAX_HZ = 1000;
	localparam logic [15:0] RATIO_MIN = 16'(MOD_HZ / RATE_MAX_HZ);
	localparam logic [15:0] RATIO_MAX = 16'(MOD_HZ / RATE_MIN_HZ);
	localparam int RES_MAX = 32767;

	localparam logic [7:0] OFF_STA  = 8'h00;
	localparam logic [7:0] OFF_MSK  = 8'h04;
	localparam logic [7:0] OFF_MODE = 8'h08;
	localparam logic [7:0] OFF_FLT  = 8'h18;
	localparam logic [7:0] OFF_CFG  = 8'h1C;
	localparam logic [7:0] OFF_CUR  = 8'h20;
	localparam logic [7:0] OFF_VT   = 8'h24;
	localparam logic [7:0] OFF_LIM  = 8'h48;
	localparam logic [7:0] OFF_CNT  = 8'h4C;
	localparam logic [7:0] OFF_TH   = 8'h50;
	localparam logic [7:0] OFF_ACC  = 8'h5C;

	localparam int M_CUR_EN  = 0;
	localparam int M_VT_EN   = 1;
	localparam int M_CORE_DN = 2;
	localparam int M_CONT    = 3;
	localparam int M_CHOP    = 4;
	localparam int M_VT_SEL  = 5;
	localparam int M_GND_DIR = 6;
	localparam int M_GND_RES = 7;
	localparam int C_CMP     = 0;
	localparam int C_ACC     = 1;
	localparam int C_CNT     = 2;
	localparam int F_SHIFT   = 16;

	localparam int S_RDY_C = 0;
	localparam int S_RDY_V = 1;
	localparam int S_RDY_T = 2;
	localparam int S_THR   = 4;
	localparam int S_CONT  = 5;
	localparam int S_CNT   = 6;
	localparam int S_ERR_C = 12;
	localparam int S_ERR_V = 13;

	localparam logic [7:0]  MODE_RST  = 8'h00;
	localparam logic [7:0]  MSK_RST   = 8'h00;
	localparam logic [2:0]  CFG_RST   = 3'h0;
	localparam logic [15:0] LIM_RST   = 16'h0001;
	localparam logic [15:0] TH_RST    = 16'h0000;
	localparam logic [5:0]  SHIFT_RST = 6'h0C;
	localparam logic [1:0]  SETTLE_NOCHOP = 2'h3;
	localparam logic [1:0]  SETTLE_CHOP   = 2'h2;
endpackage

// File: pkg/result_if.sv
// Carries one decimated result from a filter to the control logic.
// Assumes the producer drives every field from flip-flops.
`timescale 1ns/1ps
interface result_if;
	logic        vld;
	logic [15:0] dat;
	logic        ovr;
	logic        settled;
	modport dec (output vld, output dat, output ovr, output settled);
	modport ctl (input vld, input dat, input ovr, input settled);
endinterface

// File: verilog/mod_rate_div.sv
// Divider giving the one-cycle modulator step strobe.
// Assumes a single free-running system clock.
`timescale 1ns/1ps
module mod_rate_div #(
	parameter int DIV = adc_ctl_pkg::MOD_DIV
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt_q == 16'(DIV - 1));
			cnt_q  <= (cnt_q == 16'(DIV - 1)) ? 16'h0000 : cnt_q + 16'h0001;
		end
	end
endmodule

// File: verilog/sinc3_decim.sv
// Third-order decimation filter turning one modulator bitstream into
// clamped 16-bit results. Assumes bit_i is valid whenever en_i pulses.
`timescale 1ns/1ps
module sinc3_decim #(
	parameter int W = 50
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        en_i,
	input  wire logic        bit_i,
	input  wire logic        restart_i,
	input  wire logic [15:0] ratio_i,
	input  wire logic [5:0]  shift_i,
	input  wire logic [1:0]  settle_i,
	result_if.dec            res
);
	import adc_ctl_pkg::*;
	localparam logic signed [W-1:0] HI = W'(RES_MAX);
	localparam logic signed [W-1:0] LO = -HI - W'(1);
	logic signed [W-1:0] i1_q, i2_q, i3_q, z0_q, z1_q, z2_q;
	logic signed [W-1:0] c1, c2, c3, sc, i3n;
	logic [15:0]         n_q;
	logic [1:0]          oc_q;
	logic                tick;

	assign tick = en_i && (n_q == ratio_i - 16'h0001);
	// The comb takes the last integrator with this strobe's sample in it.
	// Sampling one step early leaves the third result one count off settled.
	assign i3n  = i3_q + i2_q;
	assign c1   = i3n - z0_q;
	assign c2   = c1 - z1_q;
	assign c3   = c2 - z2_q;
	assign sc   = c3 >>> shift_i;

	// A one maps to +1 and a zero to -1, so an idle input sits at mid scale.
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			i1_q <= '0;
			i2_q <= '0;
			i3_q <= '0;
			n_q  <= 16'h0000;
		end else if (en_i) begin
			i1_q <= i1_q + {{(W-1){~bit_i}}, 1'b1};
			i2_q <= i2_q + i1_q;
			i3_q <= i3_q + i2_q;
			n_q  <= tick ? 16'h0000 : n_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			z0_q        <= '0;
			z1_q        <= '0;
			z2_q        <= '0;
			oc_q        <= 2'h0;
			res.vld     <= 1'b0;
			res.dat     <= 16'h0000;
			res.ovr     <= 1'b0;
			res.settled <= 1'b0;
		end else begin
			res.vld <= tick;
			if (tick) begin
				z0_q        <= i3n;
				z1_q        <= c1;
				z2_q        <= c2;
				res.settled <= (oc_q >= settle_i - 2'h1);
				oc_q        <= (oc_q == 2'h3) ? oc_q : oc_q + 2'h1;
				res.ovr     <= (sc > HI) || (sc < LO);
				if (sc > HI) begin
					res.dat <= 16'h7FFF;
				end else if (sc < LO) begin
					res.dat <= 16'h8000;
				end else begin
					res.dat <= sc[15:0];
				end
			end
		end
	end
endmodule

// File: verilog/adc_ctl.sv
// Control, result and status logic for two sigma-delta converter channels.
// Assumes classic Wishbone from software and synchronous modulator bits.
// How it works
// - Each channel decimates its bitstream to 16-bit results at 10 Hz to 1 kHz.
// - Current channel counts conversions and flags when the programmed count elapses.
// - Current result magnitudes above the programmed threshold raise an interrupt flag.
// - With accumulation on, every settled current result adds into a 32-bit sum.
// - Current channel settles after three conversions, or two with chopping.
// - Continuous option flags every current conversion, settled or not.
// - Voltage/temperature channel settles three conversions after an input change.
// - Second channel input selects battery voltage or on-chip temperature sensor.
// - Status upper byte holds flags that never reach the interrupt.
// - Status low-byte flags are ORed into one interrupt request.
// - Each interrupt source has its own mask bit.
// - Reading the current result clears every result-ready flag.
// - With current channel off, reading the other result clears all ready flags.
// - A new result waits until that channel's ready flag is cleared.
// - With the core powered down, the latest result is always written.
// - Software drives the ground switch: open, grounded directly, or grounded through a resistor.
// - Comparator flags magnitude over threshold; reconfiguration clears the flag.
// - Out-of-range results clamp to full scale and set the channel error flag.
// - Continuous flag sets each current conversion and clears on current result read.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module adc_ctl #(
	parameter int W   = 50,
	parameter int DIV = adc_ctl_pkg::MOD_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        mod_cur_i,
	input  wire logic        mod_vt_i,
	output logic             mod_stb_o,
	output logic             vt_sel_o,
	output logic             chop_o,
	output logic             gnd_direct_o,
	output logic             gnd_res_o,
	output logic             irq_o
);
	import adc_ctl_pkg::*;

	result_if cres ();
	result_if vres ();

	logic [7:0]  msk_q;
	logic [7:0]  mode_q;
	logic [2:0]  cfg_q;
	logic [15:0] ratio_q;
	logic [5:0]  shift_q;
	logic [15:0] lim_q;
	logic [15:0] cnt_q;
	logic [15:0] th_q;
	logic [31:0] acc_q;
	logic [15:0] cur_q;
	logic [15:0] vt_q;
	logic        rdy_c_q;
	logic        rdy_v_q;
	logic        rdy_t_q;
	logic        thr_q;
	logic        cont_q;
	logic        cnt_f_q;
	logic        err_c_q;
	logic        err_v_q;
	logic [15:0] sta;
	logic [31:0] rd;
	logic [31:0] wv;
	logic        req;
	logic        wr;
	logic        rd_cur;
	logic        rd_vt;
	logic        rd_sta;
	logic        reconf;
	logic        vt_switch;
	logic        clr_rdy;
	logic        cv;
	logic        vv;
	logic        cur_set;
	logic        wr_cur;
	logic        wr_vt;
	logic        core_dn;
	logic [15:0] mag;
	logic [15:0] nr;
	logic [1:0]  cur_settle;

	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr        = req && wb_we_i;
	assign rd_cur    = req && !wb_we_i && (wb_adr_i[7:2] == OFF_CUR[7:2]);
	assign rd_vt     = req && !wb_we_i && (wb_adr_i[7:2] == OFF_VT[7:2]);
	assign rd_sta    = req && !wb_we_i && (wb_adr_i[7:2] == OFF_STA[7:2]);
	assign wv        = merge(rd, wb_dat_i, wb_sel_i);
	assign nr        = wv[15:0];
	assign reconf    = wr && ((wb_adr_i[7:2] == OFF_MODE[7:2])
		|| (wb_adr_i[7:2] == OFF_FLT[7:2]) || (wb_adr_i[7:2] == OFF_CFG[7:2]));
	assign vt_switch = wr && (wb_adr_i[7:2] == OFF_MODE[7:2])
		&& (wv[M_VT_SEL] != mode_q[M_VT_SEL]);
	assign core_dn   = mode_q[M_CORE_DN];
	assign cv        = cres.vld && mode_q[M_CUR_EN];
	assign vv        = vres.vld && mode_q[M_VT_EN];
	assign cur_set   = cv && cres.settled;
	assign clr_rdy   = rd_cur || (rd_vt && !mode_q[M_CUR_EN]);
	assign wr_cur    = cur_set && (!rdy_c_q || core_dn);
	assign wr_vt     = vv && vres.settled
		&& (!(mode_q[M_VT_SEL] ? rdy_t_q : rdy_v_q) || core_dn);
	assign mag       = cres.dat[15] ? 16'(~cres.dat + 16'h0001) : cres.dat;
	assign cur_settle = mode_q[M_CHOP] ? SETTLE_CHOP : SETTLE_NOCHOP;

	// Shared modulator step and one filter per channel.
	mod_rate_div #(.DIV(DIV)) u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (mod_stb_o)
	);

	sinc3_decim #(.W(W)) u_cur (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.en_i      (mod_stb_o),
		.bit_i     (mod_cur_i),
		.restart_i (reconf || !mode_q[M_CUR_EN]),
		.ratio_i   (ratio_q),
		.shift_i   (shift_q),
		.settle_i  (cur_settle),
		.res       (cres.dec)
	);

	// An input mux change is a mode write, so it restarts the current channel as well as the second one.
	sinc3_decim #(.W(W)) u_vt (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.en_i      (mod_stb_o),
		.bit_i     (mod_vt_i),
		.restart_i (reconf || vt_switch || !mode_q[M_VT_EN]),
		.ratio_i   (ratio_q),
		.shift_i   (shift_q),
		.settle_i  (SETTLE_NOCHOP),
		.res       (vres.dec)
	);

	always_comb begin
		sta          = 16'h0000;
		sta[S_RDY_C] = rdy_c_q;
		sta[S_RDY_V] = rdy_v_q;
		sta[S_RDY_T] = rdy_t_q;
		sta[S_THR]   = thr_q;
		sta[S_CONT]  = cont_q;
		sta[S_CNT]   = cnt_f_q;
		sta[S_ERR_C] = err_c_q;
		sta[S_ERR_V] = err_v_q;
	end

	always_comb begin
		case (wb_adr_i[7:2])
			OFF_STA[7:2]:  rd = {16'h0000, sta};
			OFF_MSK[7:2]:  rd = {24'h000000, msk_q};
			OFF_MODE[7:2]: rd = {24'h000000, mode_q};
			OFF_FLT[7:2]:  rd = {10'h000, shift_q, ratio_q};
			OFF_CFG[7:2]:  rd = {29'h00000000, cfg_q};
			OFF_CUR[7:2]:  rd = {16'h0000, cur_q};
			OFF_VT[7:2]:   rd = {16'h0000, vt_q};
			OFF_LIM[7:2]:  rd = {16'h0000, lim_q};
			OFF_CNT[7:2]:  rd = {16'h0000, cnt_q};
			OFF_TH[7:2]:   rd = {16'h0000, th_q};
			OFF_ACC[7:2]:  rd = acc_q;
			default:       rd = 32'h00000000;
		endcase
	end

	// Every access is answered one cycle after the strobe; unmapped words read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			msk_q        <= MSK_RST;
			mode_q       <= MODE_RST;
			cfg_q        <= CFG_RST;
			ratio_q      <= RATIO_MIN;
			shift_q      <= SHIFT_RST;
			lim_q        <= LIM_RST;
			th_q         <= TH_RST;
			gnd_direct_o <= 1'b0;
			gnd_res_o    <= 1'b0;
		end else if (wr) begin
			case (wb_adr_i[7:2])
				OFF_MSK[7:2]: msk_q <= wv[7:0];
				OFF_MODE[7:2]: begin
					mode_q       <= wv[7:0];
					gnd_direct_o <= wv[M_GND_DIR];
					gnd_res_o    <= wv[M_GND_RES] && !wv[M_GND_DIR];
				end
				OFF_FLT[7:2]: begin
					// Out-of-range ratios are pinned so the rate stays within limits.
					ratio_q <= (nr < RATIO_MIN) ? RATIO_MIN
						: (nr > RATIO_MAX) ? RATIO_MAX : nr;
					shift_q <= wv[F_SHIFT +: 6];
				end
				OFF_CFG[7:2]: cfg_q <= wv[2:0];
				OFF_LIM[7:2]: lim_q <= (nr == 16'h0000) ? LIM_RST : nr;
				OFF_TH[7:2]:  th_q <= nr;
				default: begin
				end
			endcase
		end
	end

	assign vt_sel_o = mode_q[M_VT_SEL];
	assign chop_o   = mode_q[M_CHOP];

	// Set always wins over a clear arriving in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdy_c_q <= 1'b0;
			rdy_v_q <= 1'b0;
			rdy_t_q <= 1'b0;
		end else begin
			rdy_c_q <= wr_cur || (rdy_c_q && !clr_rdy);
			rdy_v_q <= (wr_vt && !mode_q[M_VT_SEL]) || (rdy_v_q && !clr_rdy);
			rdy_t_q <= (wr_vt && mode_q[M_VT_SEL]) || (rdy_t_q && !clr_rdy);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_q   <= 16'h0000;
			vt_q    <= 16'h0000;
			err_c_q <= 1'b0;
			err_v_q <= 1'b0;
		end else begin
			if (wr_cur) begin
				cur_q   <= cres.dat;
				err_c_q <= cres.ovr;
			end
			if (wr_vt) begin
				vt_q    <= vres.dat;
				err_v_q <= vres.ovr;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cont_q <= 1'b0;
		end else begin
			cont_q <= (cv && mode_q[M_CONT]) || (cont_q && !rd_cur);
		end
	end

	// The threshold test sees every settled result, held back or not.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_q <= 1'b0;
		end else begin
			thr_q <= (cur_set && cfg_q[C_CMP] && (mag > th_q))
				|| (thr_q && !reconf);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || reconf) begin
			cnt_q   <= 16'h0000;
			cnt_f_q <= 1'b0;
		end else begin
			if (cur_set && cfg_q[C_CNT]) begin
				cnt_q <= (cnt_q == lim_q - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
			end
			cnt_f_q <= (cur_set && cfg_q[C_CNT] && (cnt_q == lim_q - 16'h0001))
				|| (cnt_f_q && !rd_sta);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || reconf) begin
			acc_q <= 32'h00000000;
		end else if (cur_set && cfg_q[C_ACC]) begin
			acc_q <= acc_q + {{16{cres.dat[15]}}, cres.dat};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(sta[7:0] & msk_q);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence cur_read_s;
		rd_cur && !wr_cur && !wr_vt;
	endsequence

	sequence vt_read_s;
		rd_vt && !mode_q[M_CUR_EN] && !wr_cur && !wr_vt;
	endsequence

	sequence held_s;
		rdy_c_q && !core_dn && !clr_rdy;
	endsequence

	rdy_clear_a: assert property (cur_read_s |=> !rdy_c_q && !rdy_v_q && !rdy_t_q)
		else $error("ready flags survived a current result read");
	vt_clear_a: assert property (vt_read_s |=> !rdy_c_q && !rdy_v_q && !rdy_t_q)
		else $error("ready flags survived a second result read");
	result_hold_a: assert property (held_s ##0 cres.vld |=> $stable(cur_q))
		else $error("current result overwritten while ready");
	down_write_a: assert property (cur_set && core_dn |=> cur_q == $past(cres.dat))
		else $error("latest result not written in power down");
	irq_mask_a: assert property (1'b1 |=> irq_o == |($past(sta[7:0]) & $past(msk_q)))
		else $error("interrupt does not follow masked status");
	upper_flag_a: assert property (sta[7:0] == 8'h00 |=> !irq_o)
		else $error("upper status flags reached the interrupt");
	cont_flag_a: assert property (cv && mode_q[M_CONT] |=> cont_q ##1 (cont_q || $past(rd_cur)))
		else $error("continuous flag not held after a conversion");
	clamp_err_a: assert property (wr_cur && cres.ovr
		|=> err_c_q && (cur_q == 16'h7FFF || cur_q == 16'h8000))
		else $error("out of range result not clamped and flagged");
	accum_add_a: assert property (cur_set && cfg_q[C_ACC] && !reconf
		|=> acc_q == $past(acc_q) + {{16{$past(cres.dat[15])}}, $past(cres.dat)})
		else $error("accumulator missed a current result");
	thr_flag_a: assert property (cur_set && cfg_q[C_CMP] && mag > th_q |=> thr_q)
		else $error("threshold flag not set");
endmodule

// File: dv/mod_source.sv
// Stand-in for one sigma-delta modulator, giving a one-bit stream that steps on each strobe.
// Assumes the strobe is a one-cycle pulse in the clk_i domain.
`timescale 1ns/1ps
module mod_source (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       stb_i,
	input  wire logic [1:0] pat_i,
	output logic            bit_o
);
	logic phase_q;

	// A real modulator moves only on its own sample clock, so the bit holds between strobes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= 1'b0;
		end else if (stb_i) begin
			phase_q <= ~phase_q;
		end
	end

	always_comb begin
		case (pat_i)
			2'h1: bit_o = 1'b1;
			2'h2: bit_o = 1'b0;
			default: bit_o = phase_q;
		endcase
	end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the converter control block and its decimation filter.
// Assumes the design package, the result interface and the design modules are compiled first.
`timescale 1ns/1ps
module testbench;
	import adc_ctl_pkg::*;
	// A short modulator step keeps every settling run inside the cycle budget.
	localparam int DIV = 4;
	typedef struct packed {
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} row_type;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        mod_cur;
	logic        mod_vt;
	logic        mod_stb;
	logic        vt_sel;
	logic        chop;
	logic        gdir;
	logic        gres;
	logic        irq;
	logic [1:0]  dpat;
	logic [31:0] st;
	logic [15:0] vd;
	logic        ir;
	logic [31:0] q;
	logic [15:0] d;
	logic        o;
	int          k;
	int          fails;
	int          n_compared;
	int          strobes;
	row_type     rows [0:29];
	logic [7:0]  modes [0:3];
	logic [3:0]  outs [0:3];

	adc_ctl #(.DIV(DIV)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mod_cur_i(mod_cur), .mod_vt_i(mod_vt), .mod_stb_o(mod_stb), .vt_sel_o(vt_sel),
		.chop_o(chop), .gnd_direct_o(gdir), .gnd_res_o(gres), .irq_o(irq));
	mod_source cur_src (.clk_i(clk_i), .rst_i(rst_i), .stb_i(mod_stb), .pat_i(dpat),
		.bit_o(mod_cur));
	mod_source vt_src (.clk_i(clk_i), .rst_i(rst_i), .stb_i(mod_stb), .pat_i(2'h1),
		.bit_o(mod_vt));

	always @(posedge clk_i) begin
		if (rst_i) begin
			strobes <= 0;
		end else if (mod_stb === 1'b1) begin
			strobes <= strobes + 1;
		end
	end

	task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic summarize();
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wb(input row_type r, output logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= r.we;
		adr <= r.adr;
		sel <= r.sel;
		wdat <= r.dat;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		v = rdat;
		if (n == 40) begin
			fails++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Reconfigures, clears stale ready flags, then polls status until the ready bits in rm
	// show and counts the conversions that took, rounded to whole ratio periods.
	task automatic run_conv(input logic [1:0] p, input logic [31:0] flt, input logic [7:0] m,
		input logic [2:0] rm);
		int n;
		int s0;
		dpat <= p;
		wb('{1'b1, OFF_FLT, 4'hF, flt}, q);
		wb('{1'b1, OFF_MODE, 4'hF, {24'h0, m}}, q);
		s0 = strobes;
		wb('{1'b0, OFF_CUR, 4'hF, 32'h0}, q);
		n = 0;
		q = 32'h0;
		while ((q[2:0] & rm) !== rm && n < 5000) begin
			wb('{1'b0, OFF_STA, 4'hF, 32'h0}, q);
			n++;
		end
		if (n == 5000) begin
			fails++;
		end
		ir = irq;
		st = q;
		k = (strobes - s0 + int'(RATIO_MIN) / 2) / int'(RATIO_MIN);
		wb('{1'b0, OFF_VT, 4'hF, 32'h0}, q);
		vd = q[15:0];
		wb('{1'b0, OFF_CUR, 4'hF, 32'h0}, q);
		d = q[15:0];
		o = st[S_ERR_C];
	endtask

	initial begin
		clk_i = 1'b0;
		forever begin
			#2.5 clk_i = ~clk_i;
		end
	end

	// The tests need about 25000 cycles; 40000 means a hang.
	initial begin
		repeat (40000) @(posedge clk_i);
		fails++;
		summarize();
	end

	initial begin
		fails = 0;
		n_compared = 0;
		rst_i = 1'b1;
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		dpat = 2'h0;
		rows = '{'{1'b0, OFF_STA, 4'hF, 32'h0}, '{1'b0, OFF_MSK, 4'hF, 32'h0},
			'{1'b0, OFF_MODE, 4'hF, 32'h0}, '{1'b0, OFF_FLT, 4'hF, 32'h000C0200},
			'{1'b0, OFF_CFG, 4'hF, 32'h0}, '{1'b0, OFF_CUR, 4'hF, 32'h0},
			'{1'b0, OFF_VT, 4'hF, 32'h0}, '{1'b0, OFF_LIM, 4'hF, 32'h1},
			'{1'b0, OFF_CNT, 4'hF, 32'h0}, '{1'b0, OFF_TH, 4'hF, 32'h0},
			'{1'b0, OFF_ACC, 4'hF, 32'h0}, '{1'b0, 8'h30, 4'hF, 32'h0},
			'{1'b1, OFF_MSK, 4'hF, 32'hFFFFFFFF}, '{1'b0, OFF_MSK, 4'hF, 32'hFF},
			'{1'b1, OFF_MSK, 4'h0, 32'h0}, '{1'b0, OFF_MSK, 4'hF, 32'hFF},
			'{1'b1, OFF_LIM, 4'hF, 32'h0}, '{1'b0, OFF_LIM, 4'hF, 32'h1},
			'{1'b1, OFF_TH, 4'hF, 32'h1234}, '{1'b0, OFF_TH, 4'hF, 32'h1234},
			'{1'b1, OFF_STA, 4'hF, 32'hFFFF}, '{1'b0, OFF_STA, 4'hF, 32'h0},
			'{1'b1, OFF_CFG, 4'hF, 32'h7}, '{1'b0, OFF_CFG, 4'hF, 32'h7},
			'{1'b1, OFF_FLT, 4'hF, 32'h000D0400}, '{1'b0, OFF_FLT, 4'hF, 32'h000D0400},
			'{1'b1, OFF_CNT, 4'hF, 32'h9}, '{1'b0, OFF_CNT, 4'hF, 32'h0},
			'{1'b1, 8'h30, 4'hF, 32'h5}, '{1'b0, 8'h30, 4'hF, 32'h0}};
		modes = '{8'hF0, 8'h80, 8'h20, 8'h10};
		outs = '{4'b1110, 4'b0001, 4'b0100, 4'b1000};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_word("outs_reset", 32'h0, {26'h0, chop, vt_sel, gdir, gres, irq, ack});
		foreach (rows[i]) begin
			wb(rows[i], q);
			if (rows[i].we === 1'b0) begin
				chk_word("register", rows[i].dat, q);
			end
		end
		chk_word("irq_no_flag", 32'h0, {31'h0, irq});
		for (int i = 0; i < 4; i++) begin
			wb('{1'b1, OFF_MODE, 4'hF, {24'h0, modes[i]}}, q);
			chk_word("mode_pins", {28'h0, outs[i]}, {28'h0, chop, vt_sel, gdir, gres});
		end
		k = 0;
		while (mod_stb !== 1'b1 && k < 1000) begin
			@(posedge clk_i);
			k++;
		end
		@(posedge clk_i);
		k = 1;
		while (mod_stb !== 1'b1 && k < 1000) begin
			@(posedge clk_i);
			k++;
		end
		chk_word("stb_period", 32'(DIV), 32'(k));
		run_conv(2'h0, 32'h000C0200, 8'h23, 3'h5);
		chk_word("settle_nochop", 32'h3, 32'(k));
		chk_word("irq_ready", 32'h1, {31'h0, ir});
		chk_word("mid_result", 32'h0, {15'h0, o, d});
		chk_word("temp_result", {15'h0, 1'b1, 16'(RES_MAX)}, {15'h0, st[S_ERR_V], vd});
		run_conv(2'h0, 32'h000C0200, 8'h19, 3'h1);
		chk_word("settle_chop", 32'h2, 32'(k));
		chk_word("cont_flag", 32'h1, {31'h0, st[S_CONT]});
		run_conv(2'h1, 32'h000C0200, 8'h01, 3'h1);
		chk_word("over_range", {15'h0, 1'b1, 16'(RES_MAX)}, {15'h0, o, d});
		run_conv(2'h1, 32'h000D0200, 8'h01, 3'h1);
		chk_word("in_range", 32'h4000, {15'h0, o, d});
		summarize();
	end
endmodule
